// *** src/fstop_pkg.sv ***
package fstop_pkg;

    localparam int unsigned SPEED_W   = 16;
    localparam int unsigned DELAY_W   = 16;
    localparam int unsigned RAMP_W    = 16;
    localparam int unsigned COMP_W    = 16;

    // Speeds in r/min, signed two's complement
    localparam logic [SPEED_W-1:0] ZERO_SPEED_DEFAULT = 16'h0032;  // 50 r/min
    localparam logic [SPEED_W-1:0] ZERO_SPEED_HYST    = 16'h0014;  // 20 r/min

    // Shut-off delay and ramp settings count in 1 ms ticks
    localparam int unsigned CLK_HZ        = 50000000;
    localparam int unsigned TICK_US       = 1000;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000000 * TICK_US;

    localparam logic [7:0] WARN_NONE        = 8'h00;
    localparam logic [7:0] WARN_FORCED_STOP = 8'hE6;

    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_RAMP     = 3'b001,
        ST_COMP     = 3'b011,
        ST_DELAY    = 3'b010,
        ST_OFF      = 3'b110
    } seq_state_e;

    typedef struct packed {
        logic [RAMP_W-1:0]  stopDecelTimeConstant;
        logic [SPEED_W-1:0] zeroSpeedThreshold;
        logic [DELAY_W-1:0] shutoffDelayTime;
        logic [COMP_W-1:0]  freefallCompAmount;
        logic               shutoffDelayEnable;
        logic               torqueMode;
    } stop_cfg_s;

    typedef struct packed {
        logic powerStageOn;
        logic dynamicBrakeOn;
        logic brakeInterlockOut;
        logic rampActive;
        logic compActive;
    } stop_drive_s;

endpackage : fstop_pkg

// *** src/forced_stop_brake_sequencer.sv ***
`timescale 1ns/10ps
module forced_stop_brake_sequencer (
    input  wire logic                         clk,
    input  wire logic                         rstn,
    // Stop causes and servo enable, raw pins
    input  wire logic                         forcedStopInput,
    input  wire logic                         alarmActive,
    input  wire logic                         linkBroken,
    input  wire logic                         driveEnable,
    // Settings
    input  wire fstop_pkg::stop_cfg_s         cfg,
    // Measured speed, same clock
    input  wire logic [fstop_pkg::SPEED_W-1:0] motorSpeed,
    // Outputs to power stage and controller
    output      fstop_pkg::stop_drive_s       drive,
    output      logic [fstop_pkg::RAMP_W-1:0]  rampTimeConstant,
    output      logic [fstop_pkg::COMP_W-1:0]  compTravel,
    output      logic                          zeroSpeedFlag,
    output      logic [7:0]                    forcedStopWarning
);
    import fstop_pkg::*;

    // Three-stage sync; a change counts when stages two and three agree
    logic [2:0] fsSync_reg;
    logic [2:0] alSync_reg;
    logic [2:0] lkSync_reg;
    logic [2:0] enSync_reg;
    logic       fsIn_reg, alIn_reg, lkIn_reg, enIn_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fsSync_reg <= 3'h7;
            alSync_reg <= 3'h0;
            lkSync_reg <= 3'h0;
            enSync_reg <= 3'h0;
        end else begin
            fsSync_reg <= {fsSync_reg[1:0], forcedStopInput};
            alSync_reg <= {alSync_reg[1:0], alarmActive};
            lkSync_reg <= {lkSync_reg[1:0], linkBroken};
            enSync_reg <= {enSync_reg[1:0], driveEnable};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fsIn_reg <= 1'b1;
            alIn_reg <= 1'b0;
            lkIn_reg <= 1'b0;
            enIn_reg <= 1'b0;
        end else begin
            if (fsSync_reg[1] == fsSync_reg[2]) fsIn_reg <= fsSync_reg[2];
            if (alSync_reg[1] == alSync_reg[2]) alIn_reg <= alSync_reg[2];
            if (lkSync_reg[1] == lkSync_reg[2]) lkIn_reg <= lkSync_reg[2];
            if (enSync_reg[1] == enSync_reg[2]) enIn_reg <= enSync_reg[2];
        end
    end

    // Zero-speed detection with hysteresis
    wire [SPEED_W-1:0] speedMag   = motorSpeed[SPEED_W-1] ? SPEED_W'(-motorSpeed) : motorSpeed;
    wire [SPEED_W:0]   offLevel   = {1'b0, cfg.zeroSpeedThreshold} + {1'b0, ZERO_SPEED_HYST};
    wire               zsOn       = speedMag <= cfg.zeroSpeedThreshold;
    wire               zsOff      = {1'b0, speedMag} >= offLevel;
    logic zeroSpeed_reg;
    logic zeroSpeed_next;
    assign zeroSpeed_next = zsOn ? 1'b1 : (zsOff ? 1'b0 : zeroSpeed_reg);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) zeroSpeed_reg <= 1'b1;
        else       zeroSpeed_reg <= zeroSpeed_next;
    end
    assign zeroSpeedFlag = zeroSpeed_reg;

    // Stop causes
    wire decelCause = !fsIn_reg || lkIn_reg;
    wire anyCause   = decelCause || alIn_reg;
    wire useRamp    = decelCause && !alIn_reg && !cfg.torqueMode;
    wire compOk     = (cfg.freefallCompAmount != '0) && zeroSpeed_reg
                      && cfg.shutoffDelayEnable;

    // Millisecond tick, restarted on entry so a delay of N lasts N full ms
    seq_state_e         state_reg, state_next;
    logic [DELAY_W-1:0] delayCnt_reg, delayCnt_next;
    logic [15:0]        tickCnt_reg;
    wire                delayTiming = (state_reg == ST_COMP) || (state_reg == ST_DELAY);
    wire                tick        = (tickCnt_reg == 16'(TICK_CYCLES - 1));
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)                     tickCnt_reg <= 16'h0000;
        else if (tick || !delayTiming) tickCnt_reg <= 16'h0000;
        else                           tickCnt_reg <= tickCnt_reg + 16'h0001;
    end

    always_comb begin
        state_next    = state_reg;
        delayCnt_next = delayCnt_reg;
        case (state_reg)
            ST_RUN: begin
                delayCnt_next = '0;
                if (anyCause) begin
                    // Servo off: never energise the stage just to run a delay
                    if (!enIn_reg)                 state_next = ST_OFF;
                    else if (useRamp && !zeroSpeed_reg) state_next = ST_RAMP;
                    else if (compOk)               state_next = ST_COMP;
                    else                           state_next = ST_DELAY;
                end
            end
            ST_RAMP: begin
                if (alIn_reg || cfg.torqueMode)    state_next = ST_DELAY;
                else if (zeroSpeed_reg)            state_next = ST_DELAY;
            end
            ST_COMP: begin
                // Lift runs inside the delay window, stage still energised
                if (tick) delayCnt_next = delayCnt_reg + 1'b1;
                if (delayCnt_reg >= cfg.shutoffDelayTime) state_next = ST_OFF;
            end
            ST_DELAY: begin
                if (!cfg.shutoffDelayEnable)       state_next = ST_OFF;
                else begin
                    if (tick) delayCnt_next = delayCnt_reg + 1'b1;
                    if (delayCnt_reg >= cfg.shutoffDelayTime) state_next = ST_OFF;
                end
            end
            ST_OFF: begin
                if (!anyCause && !enIn_reg)        state_next = ST_RUN;
            end
            default: state_next = ST_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg    <= ST_OFF;
            delayCnt_reg <= '0;
        end else begin
            state_reg    <= state_next;
            delayCnt_reg <= delayCnt_next;
        end
    end

    // Registered outputs; ST_OFF waits for enable low so a fresh enable edge restarts
    stop_drive_s drive_next;
    logic [7:0]  warn_next;
    logic        running;
    assign running = (state_next == ST_RUN) && enIn_reg;

    always_comb begin
        drive_next.powerStageOn      = (state_next != ST_OFF) && (state_next != ST_RUN || running);
        drive_next.dynamicBrakeOn    = (state_next == ST_OFF);
        drive_next.brakeInterlockOut = running;
        drive_next.rampActive        = (state_next == ST_RAMP);
        drive_next.compActive        = (state_next == ST_COMP);
        // Ramp keeps the warning even if the cause clears mid-ramp
        warn_next = ((state_next == ST_RAMP) || (decelCause && state_next != ST_RUN))
                    ? WARN_FORCED_STOP : WARN_NONE;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drive             <= '{powerStageOn: 1'b0, dynamicBrakeOn: 1'b1,
                                   brakeInterlockOut: 1'b0, rampActive: 1'b0,
                                   compActive: 1'b0};
            forcedStopWarning <= WARN_NONE;
            rampTimeConstant  <= '0;
            compTravel        <= '0;
        end else begin
            drive             <= drive_next;
            forcedStopWarning <= warn_next;
            rampTimeConstant  <= cfg.stopDecelTimeConstant;
            compTravel        <= drive_next.compActive ? cfg.freefallCompAmount : '0;
        end
    end

    a_ramp_torque: assert property (@(posedge clk) disable iff (!rstn)
        cfg.torqueMode |=> !drive.rampActive || $past(state_reg) == ST_RAMP)
        else $error("ramp active in torque mode");

    a_brake_first: assert property (@(posedge clk) disable iff (!rstn)
        $fell(drive.powerStageOn) |-> !drive.brakeInterlockOut)
        else $error("power cut before brake interlock dropped");

    a_cut_after_drop: assert property (@(posedge clk) disable iff (!rstn)
        ($fell(drive.powerStageOn) && $past(state_reg) != ST_RUN)
        |-> !$past(drive.brakeInterlockOut))
        else $error("interlock not dropped a cycle before power cut");

    a_zero_stop: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg == ST_RAMP && zeroSpeed_reg && !alIn_reg && !cfg.torqueMode)
        |=> state_reg == ST_DELAY)
        else $error("ramp did not end at zero speed");

    a_off_holds: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg == ST_OFF && anyCause) |=> state_reg == ST_OFF)
        else $error("left shut-off with cause present");

    a_warn_shown: assert property (@(posedge clk) disable iff (!rstn)
        drive.rampActive |-> forcedStopWarning == WARN_FORCED_STOP)
        else $error("warning missing during ramp");

    a_zs_set: assert property (@(posedge clk) disable iff (!rstn)
        zsOn |=> zeroSpeedFlag)
        else $error("zero speed flag not set");

    a_zs_hyst: assert property (@(posedge clk) disable iff (!rstn)
        (zeroSpeedFlag && !zsOff) |=> zeroSpeedFlag)
        else $error("zero speed flag cleared inside band");

    a_comp_gate: assert property (@(posedge clk) disable iff (!rstn)
        drive.compActive |-> cfg.shutoffDelayEnable && drive.powerStageOn)
        else $error("compensation without delay or power");

    a_link_stop: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg == ST_RUN && lkIn_reg) |=> state_reg != ST_RUN)
        else $error("link break did not start stop");

    a_alarm_delay: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg == ST_RUN && alIn_reg && enIn_reg && !compOk)
        |=> state_reg == ST_DELAY)
        else $error("alarm did not start delay");

endmodule : forced_stop_brake_sequencer

// *** testbench/motor_model.sv ***
`timescale 1ns/10ps
module motor_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Bench control
    input  wire logic        loadSpeed,
    input  wire logic [15:0] loadValue,
    // Power stage side
    input  wire logic        rampActive,
    input  wire logic        powerStageOn,
    output      logic [15:0] motorSpeed
);
    // Positive speeds only; a stop ramp or coasting sheds 10 r/min a cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            motorSpeed <= 16'h0000;
        end else if (loadSpeed) begin
            motorSpeed <= loadValue;
        end else if ((rampActive || !powerStageOn) && motorSpeed != 16'h0000) begin
            motorSpeed <= (motorSpeed > 16'h000A) ? motorSpeed - 16'h000A : 16'h0000;
        end
    end
endmodule : motor_model

// *** testbench/forced_stop_brake_sequencer_tb_top.sv ***
`timescale 1ns/10ps
module forced_stop_brake_sequencer_tb_top;
    import fstop_pkg::*;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              forcedStopInput = 1'b1;
    logic              alarmActive = 1'b0;
    logic              linkBroken = 1'b0;
    logic              driveEnable = 1'b0;
    logic              loadSpeed = 1'b0;
    logic [15:0]       loadValue = 16'h0000;
    stop_cfg_s         cfg = '{16'h0064, ZERO_SPEED_DEFAULT, 16'h0001, 16'h0000, 1'b0, 1'b0};
    stop_drive_s       drive;
    logic [15:0]       motorSpeed, rampTimeConstant, compTravel;
    logic              zeroSpeedFlag;
    logic [7:0]        forcedStopWarning;
    int                n_fail = 0;
    int                compares = 0;

    always #10 clk = ~clk;

    forced_stop_brake_sequencer u_forced_stop_brake_sequencer (
        .clk(clk), .rstn(rstn), .forcedStopInput(forcedStopInput),
        .alarmActive(alarmActive), .linkBroken(linkBroken), .driveEnable(driveEnable),
        .cfg(cfg), .motorSpeed(motorSpeed), .drive(drive),
        .rampTimeConstant(rampTimeConstant), .compTravel(compTravel),
        .zeroSpeedFlag(zeroSpeedFlag), .forcedStopWarning(forcedStopWarning)
    );
    motor_model u_motor_model (
        .clk(clk), .rstn(rstn), .loadSpeed(loadSpeed), .loadValue(loadValue),
        .rampActive(drive.rampActive), .powerStageOn(drive.powerStageOn),
        .motorSpeed(motorSpeed)
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic set_speed(input logic [15:0] v);
        @(posedge clk);
        loadSpeed <= 1'b1;
        loadValue <= v;
        @(posedge clk);
        loadSpeed <= 1'b0;
        cyc(3);
    endtask : set_speed

    // Clear every cause, then servo-on from a low request
    // Each stop cause is held until the stage is cut, never pulsed
    task automatic restart();
        @(posedge clk);
        forcedStopInput <= 1'b1;
        alarmActive     <= 1'b0;
        linkBroken      <= 1'b0;
        driveEnable     <= 1'b0;
        cyc(10);
        driveEnable <= 1'b1;
        cyc(10);
        chk("power on", 16'h0001, {15'h0, drive.powerStageOn});
        chk("interlock", 16'h0001, {15'h0, drive.brakeInterlockOut});
    endtask : restart

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #1500000;
        n_fail++;
        close_out();
    end

    initial begin
        cyc(2);
        rstn <= 1'b1;
        chk("reset dbrake", 16'h0001, {15'h0, drive.dynamicBrakeOn});
        restart();
        // Hysteresis band of the zero-speed flag
        set_speed(16'h0045);
        chk("zsp at 69", 16'h0001, {15'h0, zeroSpeedFlag});
        set_speed(16'h0046);
        chk("zsp at 70", 16'h0000, {15'h0, zeroSpeedFlag});
        set_speed(16'h0033);
        chk("zsp at 51", 16'h0000, {15'h0, zeroSpeedFlag});
        set_speed(16'h0032);
        chk("zsp at 50", 16'h0001, {15'h0, zeroSpeedFlag});
        $display("Test zero speed done");
        // Forced stop from speed, ramp then cut
        set_speed(16'h00C8);
        forcedStopInput <= 1'b0;
        cyc(7);
        chk("ramp", 16'h0001, {15'h0, drive.rampActive});
        chk("ramp tc", 16'h0064, rampTimeConstant);
        chk("interlock off", 16'h0000, {15'h0, drive.brakeInterlockOut});
        chk("still powered", 16'h0001, {15'h0, drive.powerStageOn});
        chk("warning", {8'h00, WARN_FORCED_STOP}, {8'h00, forcedStopWarning});
        for (int i = 0; i < 100 && drive.powerStageOn !== 1'b0; i++) @(posedge clk);
        chk("cut at zero", 16'h0000, {15'h0, drive.powerStageOn});
        chk("dbrake", 16'h0001, {15'h0, drive.dynamicBrakeOn});
        forcedStopInput <= 1'b1;
        cyc(10);
        chk("stays off", 16'h0000, {15'h0, drive.powerStageOn});
        $display("Test forced stop done");
        // Link break in torque mode: no ramp
        restart();
        cfg.torqueMode <= 1'b1;
        set_speed(16'h00C8);
        linkBroken <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            chk("no ramp", 16'h0000, {15'h0, drive.rampActive});
        end
        chk("link cut", 16'h0000, {15'h0, drive.powerStageOn});
        chk("link warn", {8'h00, WARN_FORCED_STOP}, {8'h00, forcedStopWarning});
        $display("Test link break done");
        // Alarm at standstill with lift and a 1 ms delay
        cfg.torqueMode <= 1'b0;
        restart();
        cfg.freefallCompAmount <= 16'h0005;
        cfg.shutoffDelayEnable <= 1'b1;
        set_speed(16'h0000);
        alarmActive <= 1'b1;
        cyc(7);
        chk("comp", 16'h0001, {15'h0, drive.compActive});
        chk("travel", 16'h0005, compTravel);
        chk("lift interlock", 16'h0000, {15'h0, drive.brakeInterlockOut});
        cyc(TICK_CYCLES - 500);
        chk("delay powered", 16'h0001, {15'h0, drive.powerStageOn});
        for (int i = 0; i < 1000 && drive.powerStageOn !== 1'b0; i++) @(posedge clk);
        chk("delay cut", 16'h0000, {15'h0, drive.powerStageOn});
        chk("travel off", 16'h0000, compTravel);
        $display("Test alarm delay done");
        // Alarm while moving: no lift, no ramp, zero delay
        restart();
        cfg.shutoffDelayTime <= 16'h0000;
        set_speed(16'h00C8);
        alarmActive <= 1'b1;
        cyc(7);
        chk("moving no comp", 16'h0000, {15'h0, drive.compActive});
        chk("alarm no ramp", 16'h0000, {15'h0, drive.rampActive});
        chk("alarm cut", 16'h0000, {15'h0, drive.powerStageOn});
        chk("alarm dbrake", 16'h0001, {15'h0, drive.dynamicBrakeOn});
        chk("alarm no warn", 16'h0000, {8'h00, forcedStopWarning});
        // Forced stop while servo is off keeps the stage dark
        @(posedge clk);
        alarmActive <= 1'b0;
        driveEnable <= 1'b0;
        cyc(10);
        chk("servo off dbrake", 16'h0000, {15'h0, drive.dynamicBrakeOn});
        forcedStopInput <= 1'b0;
        cyc(10);
        chk("off stop power", 16'h0000, {15'h0, drive.powerStageOn});
        chk("off stop dbrake", 16'h0001, {15'h0, drive.dynamicBrakeOn});
        $display("Test alarm moving done");
        close_out();
    end
endmodule : forced_stop_brake_sequencer_tb_top
